// File: design/spirp_link.sv
// Serial engine clocked by the host serial clock
`timescale 1ns/10ps
`include "spirp_map.svh"
module spirp_link (
  input wire logic sclk, // Host serial clock
  input wire logic cs_n, // Select, active low
  input wire logic host_data_input_line, // Separate data input
  input wire logic sdio_in, // Shared data line, input side
  output logic sdio_out, // Shared data line, output side
  output logic sdio_oe, // High while the port drives the data line
  spirp_xfer_if.link xf // Crossing to the system clock side
);

  logic smp_clk;
  logic lch_clk;
  logic din;
  logic [4:0] acnt;
  logic in_data;
  logic rw;
  logic [13:0] ash;
  logic [2:0] wcnt;
  logic [6:0] wsh;
  logic [3:0] alen;
  logic [2:0] ocnt;
  logic obyte;
  logic [6:0] osh;

  // -----------------------------------------------------------------------
  // Edge, data input and offset length selection
  // -----------------------------------------------------------------------
  assign smp_clk = xf.cfg.sample_fall ? ~sclk : sclk; // [RULE10]
  assign lch_clk = xf.cfg.read_late ? smp_clk : ~smp_clk; // [RULE11]
  assign din = xf.cfg.three_wire ? sdio_in : host_data_input_line; // [RULE1]
  assign alen = xf.cfg.long_offset ? `SPIRP_LONG_OFF_BITS :
                `SPIRP_SHORT_OFF_BITS; // [RULE5] [RULE7]

  // -----------------------------------------------------------------------
  // Direction, offset and write data capture
  // -----------------------------------------------------------------------
  always_ff @(posedge smp_clk or posedge cs_n)
  begin
    if (cs_n)
    begin
      acnt <= 5'h00; // [RULE21]
      in_data <= 1'b0;
      rw <= 1'b0;
      ash <= 14'h0000;
      wcnt <= 3'h0;
      wsh <= 7'h00;
    end
    else if (!in_data)
    begin
      if (acnt == 5'h00)
      begin
        rw <= din; // [RULE3]
      end
      ash <= {ash[12:0], din};
      acnt <= acnt + 5'h01;
      if (acnt == {1'b0, alen})
      begin
        in_data <= 1'b1;
      end
    end
    else
    begin
      wsh <= {wsh[5:0], din}; // [RULE17]
      wcnt <= wcnt + 3'h1;
    end
  end

  // -----------------------------------------------------------------------
  // Events toward the system side; toggles survive across frames
  // -----------------------------------------------------------------------
  always_ff @(posedge smp_clk or posedge xf.link_rst)
  begin
    if (xf.link_rst)
    begin
      xf.ev_tgl <= 1'b0;
      xf.ev_is_addr <= 1'b0;
      xf.ev_rw <= 1'b0;
      xf.ev_addr <= 15'h0000;
      xf.ev_wdata <= 8'h00;
    end
    else if (!cs_n && !in_data && acnt == {1'b0, alen})
    begin
      xf.ev_tgl <= ~xf.ev_tgl;
      xf.ev_is_addr <= 1'b1;
      xf.ev_rw <= rw;
      xf.ev_addr <= xf.cfg.long_offset ? {ash[13:0], din} :
                    {8'h00, ash[5:0], din};
    end
    else if (!cs_n && in_data && wcnt == 3'h7)
    begin
      xf.ev_tgl <= ~xf.ev_tgl; // [RULE15]
      xf.ev_is_addr <= 1'b0;
      xf.ev_wdata <= {wsh, din};
    end
  end

  // -----------------------------------------------------------------------
  // Read data launch, most significant bit first
  // -----------------------------------------------------------------------
  always_ff @(posedge lch_clk or posedge cs_n)
  begin
    if (cs_n)
    begin
      sdio_oe <= 1'b0; // [RULE22]
      sdio_out <= 1'b0;
      ocnt <= 3'h0;
      obyte <= 1'b0;
      osh <= 7'h00;
    end
    else if (rw && in_data)
    begin
      sdio_oe <= 1'b1; // [RULE18] [RULE22]
      ocnt <= ocnt + 3'h1;
      if (ocnt == 3'h0)
      begin
        sdio_out <= obyte ? xf.rd_buf1[7] : xf.rd_buf0[7]; // [RULE16]
        osh <= obyte ? xf.rd_buf1[6:0] : xf.rd_buf0[6:0];
      end
      else
      begin
        sdio_out <= osh[6];
        osh <= {osh[5:0], 1'b0};
      end
      if (ocnt == 3'h7)
      begin
        obyte <= ~obyte;
      end
    end
  end

endmodule : spirp_link

// File: design/spirp_map.svh
// Offsets, field positions, reset values and timing counts of the port
`ifndef SPIRP_MAP_SVH
`define SPIRP_MAP_SVH

// -------------------------------------------------------------------------
// Address formation
// -------------------------------------------------------------------------
`define SPIRP_SHORT_OFF_BITS 4'd7
`define SPIRP_LONG_OFF_BITS 4'd15
`define SPIRP_USER_SPACE_BIT 15

// -------------------------------------------------------------------------
// Page register (address_page_select)
// -------------------------------------------------------------------------
`define SPIRP_PAGE_OFF_SHORT 7'h7c
`define SPIRP_PAGE_OFF_LONG 15'h7ffd
`define SPIRP_PAGE_BYTES_SHORT 3'd4
`define SPIRP_PAGE_BYTES_LONG 3'd3
`define SPIRP_PAGE_TOP_BIT 7
`define SPIRP_PAGE_RESET 24'h000000

// -------------------------------------------------------------------------
// Timing
// -------------------------------------------------------------------------
`define SPIRP_CLK_SYS_MHZ 125
`define SPIRP_FETCH_NS 200
`define SPIRP_FETCH_CYC ((`SPIRP_FETCH_NS * `SPIRP_CLK_SYS_MHZ) / 1000)

`endif

// File: design/spirp_pkg.sv
// Types shared by the serial register port modules
package spirp_pkg;

  typedef struct packed {
    logic long_offset;
    logic sample_fall;
    logic read_late;
    logic three_wire;
  } spirp_cfg_t;

  typedef enum logic [1:0] {
    SPIRP_IDLE = 2'b00,
    SPIRP_ISSUE = 2'b01,
    SPIRP_WAIT = 2'b10
  } spirp_state_t;

endpackage : spirp_pkg

// File: design/spirp_port.sv
// Serial register port: host access to the 16-bit register space
// Operation
// RULE1: Supports 4-wire with separate lines and 3-wire with one shared line.
// RULE2: Wire count defaults to 4-wire unless the loaded setting says 3-wire.
// RULE3: First bit is direction: high reads, low writes.
// RULE4: Short mode address is nine page bits joined with seven offset bits.
// RULE5: Short mode sends direction then only seven offset bits.
// RULE6: Short mode page register sits at offset 0x7C, written as 4 bytes.
// RULE7: Long mode address is page top bit plus fifteen offset bits.
// RULE8: Host sets page top bit to one once in long mode.
// RULE9: Long mode page register sits at offset 0x7FFD, written as 3 bytes.
// RULE10: A setting picks rising or falling serial clock edge for sampling.
// RULE11: A setting moves read data launch by half a serial clock period.
// RULE12: All port settings come from defaults or the image loaded at reset.
// RULE13: Host moves all bytes of a wide register in one burst.
// RULE14: Host bursts never run past the end of the current page.
// RULE15: Address pointer starts at offset, advances after each data byte.
// RULE16: Read bytes go out MSB first; input line ignored meanwhile.
// RULE17: Write bytes arrive MSB first right after the last offset bit.
// RULE18: In 3-wire the port drives the data line only for read data.
// RULE19: A begun burst holds the shared register bus until it ends.
// RULE20: Space is 64KB; only the upper 32KB holds user registers.
// RULE21: Select frames each transfer; bit counting restarts at each select.
// RULE22: Output line floats except while shifting read data, so it also floats when idle.
`timescale 1ns/10ps
`include "spirp_map.svh"
module spirp_port #(
  parameter int FETCH_CYC = `SPIRP_FETCH_CYC // Read fetch budget, cycles
) (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic sclk, // Host serial clock
  input wire logic cs_n, // Select, active low
  input wire logic host_data_input_line, // Separate data input line
  input wire logic sdio_in, // Shared data line, input side
  output logic sdio_out, // Shared data line, output side
  output logic sdio_oe, // High while the port drives the data line
  input wire logic boot_long_offset, // Loaded offset mode setting
  input wire logic boot_sample_fall, // Loaded sampling edge setting
  input wire logic boot_read_late, // Loaded read placement setting
  input wire logic boot_three_wire, // Loaded wire count setting
  output logic bus_lock, // Holds the shared register bus
  output logic bus_req, // Register access request
  output logic bus_we, // Access is a write
  output logic [15:0] bus_addr, // Register address
  output logic [7:0] bus_wdata, // Write byte
  input wire logic [7:0] bus_rdata, // Read byte, valid with ack
  input wire logic bus_ack, // Access done
  output logic [23:0] page_value // Current page register contents
);

  spirp_xfer_if xf ();

  spirp_pkg::spirp_cfg_t cfg_s1;
  spirp_pkg::spirp_cfg_t cfg_s2;
  spirp_pkg::spirp_cfg_t cfg;
  spirp_pkg::spirp_state_t state;
  logic ev_s1;
  logic ev_s2;
  logic ev_s3;
  logic ev_seen;
  logic cs_s1;
  logic cs_s2;
  logic [23:0] page;
  logic [14:0] ptr;
  logic rd_mode;
  logic acc_we;
  logic [7:0] acc_wdata;
  logic [1:0] fill_cnt;
  logic slot;
  logic [15:0] full_addr;
  logic page_hit;
  logic [1:0] page_idx;
  logic [7:0] page_byte;
  logic user_hit;
  logic [14:0] next_ptr;
  logic [1:0] next_fill;

  // -----------------------------------------------------------------------
  // Settings captured while reset is held
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    cfg_s1 <= {boot_long_offset, boot_sample_fall, boot_read_late,
               boot_three_wire};
    cfg_s2 <= cfg_s1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      cfg <= cfg_s2; // [RULE12] [RULE2]
    end
  end

  assign xf.cfg = cfg;

  // -----------------------------------------------------------------------
  // Clear of the serial-side event toggle
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    xf.link_rst <= ~nrst;
  end

  // -----------------------------------------------------------------------
  // Serial engine
  // -----------------------------------------------------------------------
  spirp_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .host_data_input_line(host_data_input_line),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .xf(xf)
  );

  // -----------------------------------------------------------------------
  // Crossings into the system clock
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
    end
    else
    begin
      ev_s1 <= xf.ev_tgl;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
    end
  end

  assign ev_seen = ev_s2 ^ ev_s3;

  // Frame or a pending access holds the bus so a burst completes atomically
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      bus_lock <= 1'b0;
    end
    else
    begin
      bus_lock <= ~cs_s2 | bus_req | ev_seen |
                  (state != spirp_pkg::SPIRP_IDLE); // [RULE19]
    end
  end

  // -----------------------------------------------------------------------
  // Address formation and page decode
  // -----------------------------------------------------------------------
  always_comb
  begin
    if (cfg.long_offset)
    begin
      full_addr = {page[`SPIRP_PAGE_TOP_BIT], ptr}; // [RULE7]
      page_hit = ptr >= `SPIRP_PAGE_OFF_LONG; // [RULE9]
      page_idx = 2'(ptr - `SPIRP_PAGE_OFF_LONG);
    end
    else
    begin
      full_addr = {page[15:8], page[`SPIRP_PAGE_TOP_BIT], ptr[6:0]}; // [RULE4]
      page_hit = ptr[6:0] >= `SPIRP_PAGE_OFF_SHORT; // [RULE6]
      page_idx = 2'(ptr[6:0] - `SPIRP_PAGE_OFF_SHORT);
    end
  end

  assign user_hit = full_addr[`SPIRP_USER_SPACE_BIT]; // [RULE20]

  always_comb
  begin
    unique case (page_idx)
      2'h0: page_byte = page[7:0];
      2'h1: page_byte = page[15:8];
      2'h2: page_byte = page[23:16];
      2'h3: page_byte = 8'h00;
    endcase
  end

  // Pointer step stays inside the offset field of the active mode
  always_comb
  begin
    next_ptr = ptr + 15'h0001; // [RULE15]
    if (!cfg.long_offset)
    begin
      next_ptr = {8'h00, 7'(ptr[6:0] + 7'h01)};
    end
    next_fill = fill_cnt - 2'h1;
  end

  // -----------------------------------------------------------------------
  // Access sequencer
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state <= spirp_pkg::SPIRP_IDLE;
      ptr <= 15'h0000;
      rd_mode <= 1'b0;
      acc_we <= 1'b0;
      acc_wdata <= 8'h00;
      fill_cnt <= 2'h0;
      slot <= 1'b0;
    end
    else
    begin
      unique case (state)
        spirp_pkg::SPIRP_IDLE:
        begin
          if (ev_seen && xf.ev_is_addr)
          begin
            ptr <= xf.ev_addr; // [RULE15]
            rd_mode <= xf.ev_rw; // [RULE3]
            slot <= 1'b0;
            fill_cnt <= 2'h2;
            acc_we <= 1'b0;
            if (xf.ev_rw)
            begin
              state <= spirp_pkg::SPIRP_ISSUE;
            end
          end
          else if (ev_seen)
          begin
            acc_we <= ~rd_mode;
            acc_wdata <= xf.ev_wdata;
            fill_cnt <= 2'h1;
            state <= spirp_pkg::SPIRP_ISSUE;
          end
        end
        spirp_pkg::SPIRP_ISSUE:
        begin
          if (page_hit || !user_hit)
          begin
            ptr <= next_ptr;
            slot <= slot ^ ~acc_we;
            fill_cnt <= next_fill;
            if (next_fill == 2'h0)
            begin
              state <= spirp_pkg::SPIRP_IDLE;
            end
          end
          else
          begin
            state <= spirp_pkg::SPIRP_WAIT;
          end
        end
        spirp_pkg::SPIRP_WAIT:
        begin
          if (bus_ack)
          begin
            ptr <= next_ptr;
            slot <= slot ^ ~acc_we;
            fill_cnt <= next_fill;
            state <= (next_fill == 2'h0) ? spirp_pkg::SPIRP_IDLE :
                     spirp_pkg::SPIRP_ISSUE;
          end
        end
        default:
        begin
          state <= spirp_pkg::SPIRP_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Shared register bus request
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      bus_req <= 1'b0;
      bus_we <= 1'b0;
      bus_addr <= 16'h0000;
      bus_wdata <= 8'h00;
    end
    else if (state == spirp_pkg::SPIRP_ISSUE && !page_hit && user_hit)
    begin
      bus_req <= 1'b1;
      bus_we <= acc_we;
      bus_addr <= full_addr;
      bus_wdata <= acc_wdata;
    end
    else if (state == spirp_pkg::SPIRP_WAIT && bus_ack)
    begin
      bus_req <= 1'b0;
      bus_we <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Page register writes
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      page <= `SPIRP_PAGE_RESET;
    end
    else if (state == spirp_pkg::SPIRP_ISSUE && page_hit && acc_we)
    begin
      unique case (page_idx)
        2'h0: page[7:0] <= acc_wdata; // [RULE6] [RULE9]
        2'h1: page[15:8] <= acc_wdata;
        2'h2: page[23:16] <= acc_wdata;
        2'h3: page <= page;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      page_value <= `SPIRP_PAGE_RESET;
    end
    else
    begin
      page_value <= page;
    end
  end

  // -----------------------------------------------------------------------
  // Read byte buffers, filled alternately ahead of the serial engine
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      xf.rd_buf0 <= 8'h00;
      xf.rd_buf1 <= 8'h00;
    end
    else if (!acc_we && state == spirp_pkg::SPIRP_ISSUE &&
             (page_hit || !user_hit))
    begin
      if (slot)
      begin
        xf.rd_buf1 <= page_hit ? page_byte : 8'h00; // [RULE20]
      end
      else
      begin
        xf.rd_buf0 <= page_hit ? page_byte : 8'h00;
      end
    end
    else if (!acc_we && state == spirp_pkg::SPIRP_WAIT && bus_ack)
    begin
      if (slot)
      begin
        xf.rd_buf1 <= bus_rdata; // [RULE16]
      end
      else
      begin
        xf.rd_buf0 <= bus_rdata;
      end
    end
  end

endmodule : spirp_port

// File: design/spirp_xfer_if.sv
// Crossing between the serial-clock engine and the system-clock side
`timescale 1ns/10ps
interface spirp_xfer_if;
  spirp_pkg::spirp_cfg_t cfg;
  logic link_rst;
  logic ev_tgl;
  logic ev_is_addr;
  logic ev_rw;
  logic [14:0] ev_addr;
  logic [7:0] ev_wdata;
  logic [7:0] rd_buf0;
  logic [7:0] rd_buf1;

  modport link (
    input cfg, link_rst, rd_buf0, rd_buf1,
    output ev_tgl, ev_is_addr, ev_rw, ev_addr, ev_wdata
  );
  modport core (
    output cfg, link_rst, rd_buf0, rd_buf1,
    input ev_tgl, ev_is_addr, ev_rw, ev_addr, ev_wdata
  );
endinterface : spirp_xfer_if

// File: tb/spi_slave_register_port_tb.sv
// Self-checking bench for the serial register port
`timescale 1ns/10ps
module spi_slave_register_port_tb;
  logic clk_sys, nrst, sclk, cs_n, mosi, host_drv, slow;
  logic boot_long, boot_fall, boot_late, boot_three;
  logic sdio_out, sdio_oe, bus_lock, bus_req, bus_we, bus_ack;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata;
  logic [23:0] page_value;
  wire logic din, sdio_in;
  int n_access, mismatches, n_compared, n0;
  logic [7:0] d [$];

  // In 3-wire the unused separate input line carries the inverse so it is seen to be ignored
  assign din = boot_three ? ~mosi : mosi;
  assign sdio_in = sdio_oe ? sdio_out : (host_drv ? mosi : ~mosi);

  spirp_port #(.FETCH_CYC(10)) DUT (.clk_sys(clk_sys), .nrst(nrst),
    .sclk(sclk), .cs_n(cs_n), .host_data_input_line(din),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .boot_long_offset(boot_long), .boot_sample_fall(boot_fall),
    .boot_read_late(boot_late), .boot_three_wire(boot_three),
    .bus_lock(bus_lock), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .page_value(page_value));

  spirp_regs_model u_regs (.clk_sys(clk_sys), .nrst(nrst), .slow(slow),
    .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .n_access(n_access));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_b

  task automatic chk_w(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_w

  task automatic report_and_stop;
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Host side access tasks
  // ----------------------------------------
  task automatic do_reset(input logic lng, input logic fal, input logic thr,
    input logic lat);
    nrst <= 1'b0;
    boot_long <= lng;
    boot_fall <= fal;
    boot_late <= lat;
    boot_three <= thr;
    slow <= thr;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : do_reset

  // One serial clock period; q is the line as the host samples it
  task automatic bitc(input logic b, input realtime hold, output logic q);
    mosi = b;
    #3.75;
    if (!(boot_fall ^ boot_late))
      q = sdio_oe ? sdio_out : 1'bx;
    sclk = 1'b1;
    #(hold);
    if (boot_fall ^ boot_late)
      q = sdio_oe ? sdio_out : 1'bx;
    sclk = 1'b0;
    #3.75;
  endtask : bitc

  task automatic xfer(input logic [15:0] hdr, ref logic [7:0] v [$]);
    int hb;
    int n;
    logic rd;
    logic q;
    hb = boot_long ? 16 : 8;
    rd = hdr[hb-1];
    @(posedge clk_sys);
    cs_n <= 1'b0;
    #4;
    for (int i = hb - 1; i >= 0; i--)
      bitc(hdr[i], (rd && i == 0 && !boot_fall) ? 300.0 : 7.5, q);
    if (rd && boot_fall)
      #300;
    host_drv = !rd;
    foreach (v[j])
      for (int k = 7; k >= 0; k--)
      begin
        bitc(rd ? k[0] : v[j][k], 7.5, q);
        if (rd)
          v[j][k] = q;
      end
    #4;
    cs_n = 1'b1;
    host_drv = 1'b1;
    repeat (4) @(posedge clk_sys);
    n = 0;
    while (bus_lock !== 1'b0 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 100)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask : xfer

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {nrst, sclk, mosi, slow, boot_long, boot_fall, boot_late} = 7'h00;
    {cs_n, host_drv, boot_three} = 3'b110;
    do_reset(1'b0, 1'b0, 1'b0, 1'b0);
    chk_w(page_value, 24'h000000);
    d = '{8'h80, 8'hcb, 8'h10, 8'h20};
    xfer(16'h007c, d);
    chk_w(page_value, 24'h10cb80);
    chk_w(24'(n_access), 24'h000000);
    d = '{8'h50, 8'h51};
    xfer(16'h0064, d);
    chk_b(u_regs.mem[16'hcbe4], 8'h50);
    chk_b(u_regs.mem[16'hcbe5], 8'h51);
    u_regs.mem[16'hcbe6] = 8'ha5;
    u_regs.mem[16'hcbe7] = 8'h3c;
    u_regs.mem[16'hcbe8] = 8'h00;
    d = '{8'h00, 8'h00};
    xfer(16'h00e6, d);
    chk_b(d[0], 8'ha5);
    chk_b(d[1], 8'h3c);
    d = '{8'h00, 8'h40, 8'h00, 8'h00};
    xfer(16'h007c, d);
    chk_w(page_value, 24'h004000);
    u_regs.mem[16'h4010] = 8'h77;
    u_regs.mem[16'h4011] = 8'h11;
    n0 = n_access;
    d = '{8'h99};
    xfer(16'h0011, d);
    d = '{8'h55};
    xfer(16'h0090, d);
    chk_b(d[0], 8'h00);
    chk_b(u_regs.mem[16'h4011], 8'h11);
    chk_w(24'(n_access - n0), 24'h000000);
    do_reset(1'b1, 1'b1, 1'b1, 1'b0);
    chk_w(page_value, 24'h000000);
    d = '{8'h80, 8'h10, 8'h20};
    xfer(16'h7ffd, d);
    chk_w(page_value, 24'h201080);
    d = '{8'h5a};
    xfer(16'h4be4, d);
    chk_b(u_regs.mem[16'hcbe4], 8'h5a);
    u_regs.mem[16'hc024] = 8'hc3;
    u_regs.mem[16'hc025] = 8'h96;
    u_regs.mem[16'hc026] = 8'h00;
    d = '{8'h00, 8'h00};
    xfer(16'hc024, d);
    chk_b(d[0], 8'hc3);
    chk_b(d[1], 8'h96);
    do_reset(1'b1, 1'b0, 1'b0, 1'b1);
    d = '{8'h80, 8'h10, 8'h20};
    xfer(16'h7ffd, d);
    chk_w(page_value, 24'h201080);
    d = '{8'h00, 8'h00};
    xfer(16'hc024, d);
    chk_b(d[0], 8'hc3);
    chk_b(d[1], 8'h96);
    report_and_stop();
  end
endmodule : spi_slave_register_port_tb

// File: tb/spirp_port_props.sv
// Concurrent checks on the serial register port's system side
`timescale 1ns/10ps
module spirp_port_props (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Reset, active low
  input wire logic cs_n, // Select, active low
  input wire logic sdio_oe, // Data line enable
  input wire logic bus_lock, // Bus held
  input wire logic bus_req, // Bus request
  input wire logic bus_we, // Write access
  input wire logic [15:0] bus_addr, // Bus address
  input wire logic [7:0] bus_wdata, // Write byte
  input wire logic bus_ack, // Bus done
  input wire logic [23:0] page_value // Page register
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic seen;
  logic [15:0] last_addr;

  // ----------------------------------------
  // Last completed address within one burst
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst || !bus_lock)
      seen <= 1'b0;
    else if (bus_req && bus_ack)
      seen <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (bus_req && bus_ack)
      last_addr <= bus_addr;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_REQ_HELD: assert property (bus_req && !bus_ack |=> bus_req &&
    $stable(bus_addr) && $stable(bus_we) && $stable(bus_wdata))
    else $error("request changed before its answer");
  AST_REQ_DROP: assert property (bus_req && bus_ack |=> !bus_req)
    else $error("request not released after answer");
  AST_LOCK_REQ: assert property (bus_req |-> bus_lock)
    else $error("request without bus hold");
  AST_LOCK_FRAME: assert property (cs_n == 1'b0 [*4] |-> bus_lock)
    else $error("open frame does not hold the bus");
  AST_USER_SPACE: assert property (bus_req |-> bus_addr[15])
    else $error("access below user space reached the bus");
  AST_OE_SELECT: assert property (cs_n && $past(cs_n) |-> !sdio_oe)
    else $error("data line driven while deselected");
  AST_OE_WRITE: assert property (bus_req && bus_we |-> !sdio_oe)
    else $error("data line driven during a write");
  AST_ADDR_STEP: assert property ($rose(bus_req) && seen |->
    bus_addr[6:0] == last_addr[6:0] + 7'h01)
    else $error("burst address did not advance by one");
  AST_PAGE_HOLD: assert property (cs_n [*8] |-> $stable(page_value))
    else $error("page register changed while idle");

  CVR_WRITE: cover property (bus_req && bus_we && bus_ack);
  CVR_READ: cover property (bus_req && !bus_we && bus_ack);
  CVR_DRIVE: cover property ($rose(sdio_oe));
  CVR_PAGE: cover property ($changed(page_value));
endmodule : spirp_port_props

bind spirp_port spirp_port_props u_props (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .cs_n(cs_n),
  .sdio_oe(sdio_oe),
  .bus_lock(bus_lock),
  .bus_req(bus_req),
  .bus_we(bus_we),
  .bus_addr(bus_addr),
  .bus_wdata(bus_wdata),
  .bus_ack(bus_ack),
  .page_value(page_value)
);

// File: tb/spirp_regs_model.sv
// Register file stand-in answering the port's internal bus
`timescale 1ns/10ps
module spirp_regs_model (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Reset, active low
  input wire logic slow, // Answer after extra cycles
  input wire logic bus_req, // Access request
  input wire logic bus_we, // Access is a write
  input wire logic [15:0] bus_addr, // Register address
  input wire logic [7:0] bus_wdata, // Write byte
  output logic [7:0] bus_rdata = 8'h00, // Read byte
  output logic bus_ack = 1'b0, // One-cycle done pulse
  output int n_access = 0 // Accesses answered
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_cnt = 2'h0;

  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      bus_ack <= 1'b0;
      wait_cnt <= 2'h0;
    end
    else if (bus_req && !bus_ack && wait_cnt >= (slow ? 2'h3 : 2'h0))
    begin
      bus_ack <= 1'b1;
      wait_cnt <= 2'h0;
      n_access <= n_access + 1;
      if (bus_we)
        mem[bus_addr] <= bus_wdata;
      else
        bus_rdata <= mem[bus_addr];
    end
    else
    begin
      bus_ack <= 1'b0;
      wait_cnt <= (bus_req && !bus_ack) ? wait_cnt + 2'h1 : 2'h0;
      // Released data must not repeat the last answer
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule : spirp_regs_model
